// ===== daix_regs.sv
// data address index, general register pointer and status word
`timescale 1ns/100ps
module daix_regs
   import daix_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk_in,
   input  wire logic              rst_b_in,
   // index register from datapath
   input  wire logic [ADDR_W-1:0] index_reg_in,
   // direct operand m and register operand r
   input  wire logic [ADDR_W-1:0] direct_addr_in,
   input  wire logic [COL_W-1:0]  reg_col_in,
   input  wire logic              data_mem_op_in,
   // register-indirect transfer: nibble read from register r
   input  wire logic              indirect_op_in,
   input  wire logic [NIB_W-1:0]  gpr_nibble_in,
   // system register access
   input  wire logic [SYS_W-1:0]  sys_addr_in,
   input  wire logic              sys_wr_in,
   input  wire logic [NIB_W-1:0]  sys_wdata_in,
   // flag update from alu
   input  wire logic              flag_wr_in,
   input  wire logic [NIB_W-1:0]  flag_data_in,
   // interrupt taken: save status word
   input  wire logic              irq_take_in,
   // addresses out
   output logic      [ADDR_W-1:0] direct_real_addr_out,
   output logic      [ADDR_W-1:0] gpr_addr_out,
   output logic      [ADDR_W-1:0] indirect_addr_out,
   // register read data and status
   output logic      [NIB_W-1:0]  sys_rdata_out,
   output logic      [4:0]        status_word_out,
   output logic      [4:0]        saved_status_out,
   output logic      [SYS_W-1:0]  gpr_row_pointer_out,
   output logic                   index_enable_flag_out
);
   daix_state_t state_reg;
   daix_state_t state_next;
   logic        idx_en;
   logic [ADDR_W-1:0] indirect_raw;

   // index enable flag sits in the status nibble
   assign idx_en = state_reg.status_nibble[INDEX_EN_BIT];
   assign index_enable_flag_out = idx_en;

   // direct operand: all three fields ORed with the index
   daix_addr_mod u_direct (
      .addr_in       (direct_addr_in),
      .index_reg_in  (index_reg_in),
      .enable_in     (idx_en & data_mem_op_in),
      .col_keep_in   (1'b0),
      .real_addr_out (direct_real_addr_out)
   );

   // indirect: bank/row of m, column from the general register nibble
   assign indirect_raw = {direct_addr_in[ADDR_W-1:COL_W], gpr_nibble_in};
   daix_addr_mod u_indirect (
      .addr_in       (indirect_raw),
      .index_reg_in  (index_reg_in),
      .enable_in     (idx_en & indirect_op_in),
      .col_keep_in   (1'b1),
      .real_addr_out (indirect_addr_out)
   );

   // general register row: bank zero, pointer row, column r
   assign gpr_addr_out = {BANK_ZERO, state_reg.gpr_row_pointer,
                          reg_col_in};
   // register operand stays in its row regardless of index
   assign gpr_row_pointer_out = {PTR_HI_READ,
                                 state_reg.gpr_row_pointer};
   assign status_word_out  = {state_reg.decimal_flag,
                              state_reg.status_nibble};
   assign saved_status_out = state_reg.saved_status_word;
   assign sys_rdata_out    = state_reg.rd_data;

   // next state: writes, flag updates, interrupt save, read mux
   always_comb begin
      state_next = state_reg;
      if (sys_wr_in) begin
         unique case (sys_addr_in)
            GPR_PTR_LOW_ADDR: begin
               state_next.gpr_row_pointer =
                  sys_wdata_in[NIB_W-1:PTR_LOW_LSB];
               state_next.decimal_flag = sys_wdata_in[DECIMAL_BIT];
            end
            STATUS_NIB_ADDR: begin
               state_next.status_nibble = sys_wdata_in;
            end
            default: begin
               state_next.status_nibble = state_reg.status_nibble;
            end
         endcase
      end else if (flag_wr_in) begin
         state_next.status_nibble[COMPARE_BIT:ZERO_BIT] =
            flag_data_in[COMPARE_BIT:ZERO_BIT];
      end
      if (irq_take_in) begin
         state_next.saved_status_word = {state_reg.decimal_flag,
                                         state_reg.status_nibble};
      end
      unique case (sys_addr_in)
         GPR_PTR_HIGH_ADDR: state_next.rd_data = PTR_HI_READ;
         GPR_PTR_LOW_ADDR:  state_next.rd_data =
            {state_next.gpr_row_pointer, state_next.decimal_flag};
         STATUS_NIB_ADDR:   state_next.rd_data = state_next.status_nibble;
         default:           state_next.rd_data = NIB_RESET;
      endcase
   end

   // state register, all cleared at reset
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_reg.gpr_row_pointer   <= PTR_RESET;
         state_reg.decimal_flag      <= 1'b0;
         state_reg.status_nibble     <= NIB_RESET;
         state_reg.saved_status_word <= STATUS_RST;
         state_reg.rd_data           <= NIB_RESET;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : daix_regs

// ===== daix_pkg.sv
// package: constants and types for data address index and status registers
// Overview of operation
// - index enable modifies direct operand addresses
// - index ORs bank, row and column fields
// - indirect bank and row also index modified
// - row pointer: 7DH nibble plus 7EH upper bits
// - 7DH reads zero; pointer clears at reset
// - pointer row is general register, r selects column
// - general register only in bank zero rows 0-7
// - register operand in row, memory operand anywhere
// - status word: decimal at 7EH, four flags 7FH
// - status clears at reset, saved on interrupt
// - real address is operand OR index register
// - index enable 0 disables, 1 enables modification
package daix_pkg;
   // address layout: 4 bank bits, 3 row bits, 4 column bits
   localparam int ADDR_W = 11;
   localparam int BANK_W = 4;
   localparam int ROW_W  = 3;
   localparam int COL_W  = 4;
   localparam int NIB_W  = 4;
   localparam int SYS_W  = 7;
   // system register addresses (row and column within bank 0)
   localparam logic [SYS_W-1:0] GPR_PTR_HIGH_ADDR = 7'h7D;
   localparam logic [SYS_W-1:0] GPR_PTR_LOW_ADDR  = 7'h7E;
   localparam logic [SYS_W-1:0] STATUS_NIB_ADDR   = 7'h7F;
   // field positions
   localparam int DECIMAL_BIT  = 0;
   localparam int INDEX_EN_BIT = 0;
   localparam int ZERO_BIT     = 1;
   localparam int CARRY_BIT    = 2;
   localparam int COMPARE_BIT  = 3;
   localparam int PTR_LOW_LSB  = 1;
   // reset values
   localparam logic [NIB_W-1:0] NIB_RESET   = 4'h0;
   localparam logic [ROW_W-1:0] PTR_RESET   = 3'h0;
   localparam logic [NIB_W-1:0] PTR_HI_READ = 4'h0;
   localparam logic [4:0]       STATUS_RST  = 5'h00;
   localparam logic [BANK_W-1:0] BANK_ZERO  = 4'h0;
   // state of the block
   typedef struct packed {
      logic [ROW_W-1:0] gpr_row_pointer;
      logic             decimal_flag;
      logic [NIB_W-1:0] status_nibble;
      logic [4:0]       saved_status_word;
      logic [NIB_W-1:0] rd_data;
   } daix_state_t;
endpackage : daix_pkg

// ===== daix_addr_mod.sv
// index modification of one bank/row/column address
`timescale 1ns/100ps
module daix_addr_mod
   import daix_pkg::*;
(
   // address in
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [ADDR_W-1:0] index_reg_in,
   input  wire logic              enable_in,
   input  wire logic              col_keep_in,
   // real address out
   output logic      [ADDR_W-1:0] real_addr_out
);
   logic [ADDR_W-1:0] mask;
   // column mask is cleared when the column comes from elsewhere
   always_comb begin
      mask = index_reg_in;
      if (col_keep_in) begin
         mask[COL_W-1:0] = '0;
      end
      real_addr_out = enable_in ? (addr_in | mask) : addr_in;
   end
endmodule : daix_addr_mod

// ===== daix_regs_chk.sv
// checker: address, pointer and status relations of daix_regs
`timescale 1ns/100ps
module daix_chk
   import daix_pkg::*;
(
   // clock, reset, strobes and flags
   input wire logic ref_clk_in, rst_b_in, data_mem_op_in, indirect_op_in,
   input wire logic sys_wr_in, irq_take_in, index_enable_flag_out,
   // addresses
   input wire logic [ADDR_W-1:0] index_reg_in, direct_addr_in,
   input wire logic [ADDR_W-1:0] direct_real_addr_out, gpr_addr_out,
   input wire logic [ADDR_W-1:0] indirect_addr_out,
   // nibbles, system address and status
   input wire logic [3:0] reg_col_in, gpr_nibble_in, sys_wdata_in,
   input wire logic [3:0] sys_rdata_out,
   input wire logic [SYS_W-1:0] sys_addr_in, gpr_row_pointer_out,
   input wire logic [4:0] status_word_out, saved_status_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // index applies only with flag set and a memory operation
   a_direct_or: assert property (
      direct_real_addr_out == (direct_addr_in | ((index_enable_flag_out &&
      data_mem_op_in) ? index_reg_in : 11'h000))) else $error("direct addr");
   a_indirect_addr: assert property (
      indirect_addr_out == {direct_addr_in[10:4] | ((index_enable_flag_out
      && indirect_op_in) ? index_reg_in[10:4] : 7'h00), gpr_nibble_in})
      else $error("indirect addr");
   a_gpr_addr: assert property (
      gpr_addr_out == {4'h0, gpr_row_pointer_out[2:0], reg_col_in})
      else $error("gpr addr");
   a_ptr_high: assert property (gpr_row_pointer_out[6:3] == 4'h0)
      else $error("pointer high bits");
   a_high_reads: assert property (sys_addr_in == 7'h7D |=>
      sys_rdata_out == 4'h0) else $error("high nibble read");
   a_ptr_write: assert property (sys_wr_in && sys_addr_in == 7'h7E |=>
      {gpr_row_pointer_out[2:0], status_word_out[4]} == $past(sys_wdata_in))
      else $error("pointer write");
   a_status_write: assert property (sys_wr_in && sys_addr_in == 7'h7F |=>
      status_word_out[3:0] == $past(sys_wdata_in)) else $error("status write");
   a_irq_save: assert property (irq_take_in |=>
      saved_status_out == $past(status_word_out)) else $error("status save");
   a_flag_tie: assert property (
      index_enable_flag_out == status_word_out[0]) else $error("flag copy");
endmodule : daix_chk
bind daix_regs daix_chk u_chk (.*);

// ===== tb_top.sv
// testbench: register access, index modification and status save
`timescale 1ns/100ps
`define CHK(a,b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb_top
   import daix_pkg::*;
;
   logic ref_clk = 1'b0, rst_b = 1'b0, mem_op = 1'b0, ind_op = 1'b0;
   logic wr = 1'b0, irq = 1'b0, index_enable_flag, fw = 1'b0;
   logic [ADDR_W-1:0] idx = 11'h000, dir = 11'h000, real_a, gpr_a, ind_a;
   logic [3:0]        col = 4'h0, nib = 4'h0, wdat = 4'h0, rdat, fdat = 4'h0;
   logic [SYS_W-1:0]  sadr = 7'h00, ptr;
   logic [4:0]        sw, saved;
   int                fail_count = 0, samples_checked = 0;
   // clock
   always #20 ref_clk = ~ref_clk;
   daix_regs u_dut (.ref_clk_in(ref_clk), .rst_b_in(rst_b),
      .index_reg_in(idx), .direct_addr_in(dir), .reg_col_in(col),
      .data_mem_op_in(mem_op), .indirect_op_in(ind_op),
      .gpr_nibble_in(nib), .sys_addr_in(sadr), .sys_wr_in(wr),
      .sys_wdata_in(wdat), .flag_wr_in(fw), .flag_data_in(fdat),
      .irq_take_in(irq), .direct_real_addr_out(real_a),
      .gpr_addr_out(gpr_a), .indirect_addr_out(ind_a),
      .sys_rdata_out(rdat), .status_word_out(sw),
      .saved_status_out(saved), .gpr_row_pointer_out(ptr),
      .index_enable_flag_out(index_enable_flag));
   // one write strobe cycle
   task automatic wr_reg(input logic [6:0] a, input logic [3:0] d);
      @(posedge ref_clk); #1;
      sadr = a;
      wdat = d;
      wr = 1'b1;
      @(posedge ref_clk); #1;
      wr = 1'b0;
   endtask : wr_reg
   // present address, compare data one edge later
   task automatic rd_chk(input logic [6:0] a, input logic [3:0] e);
      @(posedge ref_clk); #1;
      sadr = a;
      @(posedge ref_clk); #1;
      `CHK(rdat, e)
   endtask : rd_chk
   task automatic conclude();
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   // watchdog
   initial begin
      #20000;
      fail_count++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      `CHK(sw, 5'h00)
      `CHK(ptr, 7'h00)
      wr_reg(7'h7E, 4'hF);
      col = 4'h9;
      #1 `CHK(ptr, 7'h07)
      `CHK(gpr_a, 11'h079)
      `CHK(sw, 5'h10)
      wr_reg(7'h7D, 4'hF);
      rd_chk(7'h7D, 4'h0);
      rd_chk(7'h7E, 4'hF);
      rd_chk(7'h00, 4'h0);
      wr_reg(7'h7F, 4'h1);
      `CHK(index_enable_flag, 1'b1)
      idx = 11'h012;
      dir = 11'h061;
      mem_op = 1'b1;
      #1 `CHK(real_a, 11'h073)
      idx = 11'h401;
      dir = 11'h034;
      ind_op = 1'b1;
      nib = 4'h8;
      #1 `CHK(real_a, 11'h435)
      `CHK(ind_a, 11'h438)
      wr_reg(7'h7F, 4'h0);
      `CHK(index_enable_flag, 1'b0)
      `CHK(real_a, 11'h034)
      `CHK(ind_a, 11'h038)
      wr_reg(7'h7F, 4'hE);
      rd_chk(7'h7F, 4'hE);
      irq = 1'b1;
      @(posedge ref_clk); #1;
      irq = 1'b0;
      `CHK(saved, 5'h1E)
      fw = 1'b1;
      fdat = 4'h2;
      @(posedge ref_clk); #1;
      fw = 1'b0;
      `CHK(sw, 5'h12)
      rst_b = 1'b0;
      #1 `CHK(ptr, 7'h00)
      `CHK(sw, 5'h00)
      `CHK(saved, 5'h00)
      rst_b = 1'b1;
      rd_chk(7'h7E, 4'h0);
      conclude();
   end
endmodule : tb_top
